// ==== hw/ahg_pkg.sv ====
// Shared constants and types for the alert heartbeat GPIO block
package ahg_pkg;

  // ==========================================================================
  // Clocking and timing
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned HB_FREQ_HZ     = 400_000;
  localparam int unsigned HB_HALF_CYC    = CLK_HZ / (2 * HB_FREQ_HZ);
  localparam int unsigned SLOW_CYCLE_MS  = 100;
  localparam int unsigned SLOW_CYC       = (CLK_HZ / 1000) * SLOW_CYCLE_MS;
  localparam int unsigned SLEEP_DELAY_MS = 1000;
  localparam int unsigned SLEEP_CYC      = (CLK_HZ / 1000) * SLEEP_DELAY_MS;
  localparam int unsigned TMR_W          = 32;
  localparam int unsigned HB_CNT_W       = 9;

  // ==========================================================================
  // Sizes
  localparam int unsigned N_PINS  = 5;
  localparam int unsigned N_HB    = 2;
  localparam int unsigned N_QTY   = 7;
  localparam int unsigned N_OC    = 2;
  localparam int unsigned N_ALERT = N_QTY + N_OC;
  localparam int unsigned MEAS_W  = 24;
  localparam int unsigned DGL_W   = 16;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_GPO_MODE = 8'h04;
  localparam logic [7:0] OFF_HB_CFG   = 8'h08;
  localparam logic [7:0] OFF_ALERT_EN = 8'h0C;
  localparam logic [7:0] OFF_ALERT    = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_OC_DGL   = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1C;
  localparam logic [7:0] OFF_THRESH   = 8'h20;
  localparam logic [7:0] OFF_MAX      = 8'h40;
  localparam logic [7:0] OFF_MIN      = 8'h60;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_SLEEP_B  = 0;
  localparam int unsigned CTRL_WAKE_B   = 1;
  localparam int unsigned ST_SLEEP_B    = 0;
  localparam int unsigned ST_STRAPLO_B  = 1;
  localparam int unsigned ST_TSD_B      = 2;
  localparam int unsigned HB_FLD_W      = 5;
  localparam int unsigned MODE_W        = 2;

  // Pin output modes, two bits per pin
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_LOW    = 2'h1;
  localparam logic [1:0] MODE_HIGH   = 2'h2;
  localparam logic [1:0] MODE_TOGGLE = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [23:0] RST_THRESH = 24'hFF_FFFF;
  localparam logic [23:0] RST_MIN    = 24'hFF_FFFF;
  localparam logic [23:0] RST_MAX    = 24'h00_0000;
  localparam logic [15:0] RST_DGL    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef logic [N_QTY-1:0][MEAS_W-1:0] ahg_meas_t;

  typedef struct packed {
    logic       oc;
    logic [2:0] pin;
    logic       en;
  } ahg_hb_cfg_s;

  typedef enum logic [1:0] {
    PW_STRAP,
    PW_AWAKE,
    PW_SLEEP
  } ahg_pwr_e;

endpackage

// ==== hw/ahg_deglitch.sv ====
// Overcurrent deglitch filter for one current channel
`timescale 1ns/1ps
`default_nettype none
module ahg_deglitch #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Filter
  input  wire logic         raw,
  input  wire logic [W-1:0] dur,
  output logic              filt
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         filt_reg;
  logic         filt_next;

  // Events no longer than dur cycles never reach the output
  always_comb begin
    cnt_next  = cnt_reg;
    filt_next = filt_reg;
    if (!raw) begin
      cnt_next  = '0;
      filt_next = 1'b0;
    end else if (cnt_reg >= dur) begin
      filt_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= '0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  assign filt = filt_reg;

endmodule
`default_nettype wire

// ==== hw/ahg_gpio_top.sv ====
// Alert heartbeat GPIO block with AXI4-Lite register access
//
// Contract
// - Each of five pins drives high, low, or toggles at 400 kHz.
// - In sleep all five general outputs are high-impedance.
// - Up to two pins act as heartbeats reporting enabled alerts.
// - Heartbeat toggles at 400 kHz, stops while an enabled alert is active.
// - Measurement above its threshold sets its alert register bit.
// - Threshold compare and min/max tracking once per 100 ms cycle.
// - Overcurrent output of each current channel passes a deglitch filter.
// - Deglitched overcurrent reported on a dedicated heartbeat pin.
// - Data line low at power-up blocks auto sleep and self-test.
// - Over-temperature resets all registers except the shutdown flag; here the strap latch and the bus port also keep their state.
// - After reset defaults, wait one second then enter sleep.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ahg_gpio_top #(
  parameter int unsigned SLOW_CYCLES  = ahg_pkg::SLOW_CYC,
  parameter int unsigned SLEEP_CYCLES = ahg_pkg::SLEEP_CYC
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Measurement and analog event inputs
  input  wire ahg_pkg::ahg_meas_t        meas,
  input  wire logic [ahg_pkg::N_OC-1:0]  oc_raw,
  input  wire logic                      over_temp,
  input  wire logic                      sda_in,
  // Pins and status outputs
  output logic [ahg_pkg::N_PINS-1:0]     general_outputs_out,
  output logic [ahg_pkg::N_PINS-1:0]     general_outputs_oe,
  output logic                           selftest_req,
  output logic                           irq
);
  import ahg_pkg::*;

  // ==========================================================================
  // Declarations
  localparam int unsigned NP = N_PINS;
  localparam int unsigned NA = N_ALERT;

  logic                 soft_rst_n;
  logic                 aw_full_reg, aw_full_next;
  logic [7:0]           aw_addr_reg, aw_addr_next;
  logic                 w_full_reg, w_full_next;
  logic [31:0]          w_data_reg, w_data_next;
  logic [3:0]           w_strb_reg, w_strb_next;
  logic                 awready_reg, wready_reg, arready_reg;
  logic                 bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]           bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]          rdata_reg, rdata_next;
  logic                 wr_fire, rd_fire;

  logic [2*NP-1:0]      mode_reg, mode_next;
  logic [2*HB_FLD_W-1:0] hb_reg, hb_next;
  logic [NA-1:0]        alert_en_reg, alert_en_next;
  logic [NA-1:0]        alert_reg, alert_next;
  logic [NA-1:0]        mask_reg, mask_next;
  logic [DGL_W-1:0]     dgl_reg, dgl_next;
  logic [MEAS_W-1:0]    thr_reg [N_QTY], thr_next [N_QTY];
  logic [MEAS_W-1:0]    max_reg [N_QTY], max_next [N_QTY];
  logic [MEAS_W-1:0]    min_reg [N_QTY], min_next [N_QTY];
  logic                 tsd_reg, tsd_next;
  logic                 strap_lo_reg, strap_lo_next;
  logic                 selftest_reg, selftest_next;
  ahg_pwr_e             pwr_reg, pwr_next;
  logic [TMR_W-1:0]     sleep_tmr_reg, sleep_tmr_next;
  logic [TMR_W-1:0]     slow_tmr_reg, slow_tmr_next;
  logic                 slow_tick;
  logic [HB_CNT_W-1:0]  hb_cnt_reg, hb_cnt_next;
  logic                 phase_reg, phase_next;
  logic                 irq_reg;
  logic [N_OC-1:0]      oc_dgl;
  logic [NP-1:0]        pin_out_next, pin_oe_next;
  logic [NP-1:0]        pin_out_reg, pin_oe_reg;
  logic [N_HB-1:0]      hb_stop;

  // Over-temperature acts as a reset for everything but its own flag, the strap latch and the bus port
  assign soft_rst_n = aresetn & ~over_temp;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a < OFF_MIN + 8'(4 * N_QTY)) && (a[1:0] == 2'h0) &&
           (a < OFF_THRESH + 8'(4 * N_QTY) || a >= OFF_MAX);
  endfunction

  // ==========================================================================
  // AXI4-Lite handshake
  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign rd_fire = s_axi_arvalid & arready_reg;

  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_fire) begin
      rdata_next = RST_ZERO;
      unique case (s_axi_araddr)
        OFF_GPO_MODE: rdata_next = 32'(mode_reg);
        OFF_HB_CFG:   rdata_next = 32'(hb_reg);
        OFF_ALERT_EN: rdata_next = 32'(alert_en_reg);
        OFF_ALERT:    rdata_next = 32'(alert_reg);
        OFF_IRQ_MASK: rdata_next = 32'(mask_reg);
        OFF_OC_DGL:   rdata_next = 32'(dgl_reg);
        OFF_STATUS: begin
          rdata_next[ST_SLEEP_B]   = (pwr_reg == PW_SLEEP);
          rdata_next[ST_STRAPLO_B] = strap_lo_reg;
          rdata_next[ST_TSD_B]     = tsd_reg;
        end
        default: begin
          for (int i = 0; i < N_QTY; i++) begin
            if (s_axi_araddr == OFF_THRESH + 8'(4 * i)) begin
              rdata_next = 32'(thr_reg[i]);
            end
            if (s_axi_araddr == OFF_MAX + 8'(4 * i)) begin
              rdata_next = 32'(max_reg[i]);
            end
            if (s_axi_araddr == OFF_MIN + 8'(4 * i)) begin
              rdata_next = 32'(min_reg[i]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= RST_ZERO;
      w_strb_reg  <= '0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= RST_ZERO;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= ~aw_full_next;
      wready_reg  <= ~w_full_next;
      arready_reg <= ~rvalid_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ==========================================================================
  // Overcurrent deglitch per channel
  for (genvar c = 0; c < N_OC; c++) begin : g_oc
    ahg_deglitch #(.W(DGL_W)) u_dgl (
      .aclk    (aclk),
      .aresetn (soft_rst_n),
      .raw     (oc_raw[c]),
      .dur     (dgl_reg),
      .filt    (oc_dgl[c])
    );
  end

  // ==========================================================================
  // Control registers, alerts and power state
  assign slow_tick = (pwr_reg == PW_AWAKE) &&
                     (slow_tmr_reg == TMR_W'(SLOW_CYCLES - 1));

  always_comb begin
    logic [31:0] wd;
    wd             = merge(RST_ZERO, w_data_reg, w_strb_reg);
    mode_next      = mode_reg;
    hb_next        = hb_reg;
    alert_en_next  = alert_en_reg;
    mask_next      = mask_reg;
    dgl_next       = dgl_reg;
    alert_next     = alert_reg;
    tsd_next       = tsd_reg;
    thr_next       = thr_reg;
    max_next       = max_reg;
    min_next       = min_reg;
    pwr_next       = pwr_reg;
    strap_lo_next  = strap_lo_reg;
    selftest_next  = 1'b0;
    sleep_tmr_next = sleep_tmr_reg;
    slow_tmr_next  = (pwr_reg == PW_AWAKE && !slow_tick) ?
                     slow_tmr_reg + TMR_W'(1) : '0;
    // Clear-on-read first, so hardware sets below win in the same cycle
    if (rd_fire && s_axi_araddr == OFF_ALERT) begin
      alert_next = '0;
    end
    if (rd_fire && s_axi_araddr == OFF_STATUS) begin
      tsd_next = 1'b0;
    end
    if (wr_fire) begin
      unique case (aw_addr_reg)
        OFF_GPO_MODE: mode_next     = 10'(merge(32'(mode_reg), w_data_reg,
                                                w_strb_reg));
        OFF_HB_CFG:   hb_next       = 10'(merge(32'(hb_reg), w_data_reg,
                                                w_strb_reg));
        OFF_ALERT_EN: alert_en_next = NA'(merge(32'(alert_en_reg),
                                                w_data_reg, w_strb_reg));
        OFF_IRQ_MASK: mask_next     = NA'(merge(32'(mask_reg), w_data_reg,
                                                w_strb_reg));
        OFF_OC_DGL:   dgl_next      = DGL_W'(merge(32'(dgl_reg), w_data_reg,
                                                   w_strb_reg));
        default: begin
          for (int i = 0; i < N_QTY; i++) begin
            if (aw_addr_reg == OFF_THRESH + 8'(4 * i)) begin
              thr_next[i] = MEAS_W'(merge(32'(thr_reg[i]), w_data_reg,
                                          w_strb_reg));
            end
          end
        end
      endcase
    end
    if (slow_tick) begin
      for (int i = 0; i < N_QTY; i++) begin
        if (meas[i] > thr_reg[i]) begin
          alert_next[i] = 1'b1;
        end
        if (meas[i] > max_reg[i]) begin
          max_next[i] = meas[i];
        end
        if (meas[i] < min_reg[i]) begin
          min_next[i] = meas[i];
        end
      end
    end
    for (int c = 0; c < N_OC; c++) begin
      if (oc_dgl[c]) begin
        alert_next[N_QTY + c] = 1'b1;
      end
    end
    if (over_temp) begin
      tsd_next = 1'b1;
    end
    // Power state machine
    case (pwr_reg)
      PW_STRAP: begin
        strap_lo_next  = ~sda_in;
        selftest_next  = sda_in;
        sleep_tmr_next = '0;
        pwr_next       = PW_AWAKE;
      end
      PW_AWAKE: begin
        if (!strap_lo_reg && sleep_tmr_reg != TMR_W'(SLEEP_CYCLES)) begin
          sleep_tmr_next = sleep_tmr_reg + TMR_W'(1);
          if (sleep_tmr_reg == TMR_W'(SLEEP_CYCLES - 1)) begin
            pwr_next = PW_SLEEP;
          end
        end
        if (wr_fire && aw_addr_reg == OFF_CTRL && wd[CTRL_SLEEP_B]) begin
          pwr_next = PW_SLEEP;
        end
      end
      PW_SLEEP: begin
        if (wr_fire && aw_addr_reg == OFF_CTRL && wd[CTRL_WAKE_B]) begin
          pwr_next = PW_AWAKE;
        end
      end
      default: pwr_next = PW_STRAP;
    endcase
  end

  // Strap is taken once after the power-up reset, not after thermal reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsd_reg       <= 1'b0;
      strap_lo_reg  <= 1'b0;
      selftest_reg  <= 1'b0;
      pwr_reg       <= PW_STRAP;
      sleep_tmr_reg <= '0;
    end else begin
      tsd_reg       <= tsd_next;
      strap_lo_reg  <= strap_lo_next;
      selftest_reg  <= selftest_next;
      pwr_reg       <= over_temp ? PW_AWAKE : pwr_next;
      sleep_tmr_reg <= over_temp ? '0 : sleep_tmr_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!soft_rst_n) begin
      mode_reg     <= '0;
      hb_reg       <= '0;
      alert_en_reg <= '0;
      alert_reg    <= '0;
      mask_reg     <= '0;
      dgl_reg      <= RST_DGL;
      slow_tmr_reg <= '0;
      thr_reg      <= '{default: RST_THRESH};
      max_reg      <= '{default: RST_MAX};
      min_reg      <= '{default: RST_MIN};
    end else begin
      mode_reg     <= mode_next;
      hb_reg       <= hb_next;
      alert_en_reg <= alert_en_next;
      alert_reg    <= alert_next;
      mask_reg     <= mask_next;
      dgl_reg      <= dgl_next;
      slow_tmr_reg <= slow_tmr_next;
      thr_reg      <= thr_next;
      max_reg      <= max_next;
      min_reg      <= min_next;
    end
  end

  // ==========================================================================
  // 400 kHz phase, pins and interrupt
  always_comb begin
    hb_cnt_next = hb_cnt_reg + HB_CNT_W'(1);
    phase_next  = phase_reg;
    if (hb_cnt_reg == HB_CNT_W'(HB_HALF_CYC - 1)) begin
      hb_cnt_next = '0;
      phase_next  = ~phase_reg;
    end
  end

  for (genvar h = 0; h < N_HB; h++) begin : g_hb
    ahg_hb_cfg_s cfg;
    assign cfg        = hb_reg[h*HB_FLD_W +: HB_FLD_W];
    // Sticky alert keeps it stopped until the flag is read away
    assign hb_stop[h] = |(alert_reg & alert_en_reg) |
                        (cfg.oc & |oc_dgl);
  end

  for (genvar p = 0; p < NP; p++) begin : g_pin
    logic [1:0] md;
    logic [N_HB-1:0] sel;
    assign md = mode_reg[MODE_W*p +: MODE_W];
    for (genvar h = 0; h < N_HB; h++) begin : g_sel
      ahg_hb_cfg_s c;
      assign c      = hb_reg[h*HB_FLD_W +: HB_FLD_W];
      assign sel[h] = c.en && (c.pin == 3'(p));
    end
    // Sleep wins over any configuration
    assign pin_oe_next[p]  = (pwr_reg != PW_SLEEP) &&
                             (|sel || md != MODE_OFF);
    assign pin_out_next[p] = (pwr_reg == PW_SLEEP) ? 1'b0 :
                             |sel ? (phase_reg & ~|(sel & hb_stop)) :
                             (md == MODE_HIGH) ? 1'b1 :
                             (md == MODE_TOGGLE) ? phase_reg : 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!soft_rst_n) begin
      hb_cnt_reg  <= '0;
      phase_reg   <= 1'b0;
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
      irq_reg     <= 1'b0;
    end else begin
      hb_cnt_reg  <= hb_cnt_next;
      phase_reg   <= phase_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
      irq_reg     <= |(alert_next & mask_next);
    end
  end

  assign s_axi_awready       = awready_reg;
  assign s_axi_wready        = wready_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = arready_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rresp         = rresp_reg;
  assign s_axi_rdata         = rdata_reg;
  assign general_outputs_out = pin_out_reg;
  assign general_outputs_oe  = pin_oe_reg;
  assign selftest_req        = selftest_reg;
  assign irq                 = irq_reg;

endmodule
`default_nettype wire

// ==== tb/ahg_assertions.sv ====
// Port checks for the alert heartbeat GPIO block
`timescale 1ns/1ps
`default_nettype none
module ahg_assertions (
  // Clock, reset and bus
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Events and pins
  input wire logic       over_temp,
  input wire logic       sda_in,
  input wire logic       selftest_req,
  input wire logic       irq,
  input wire logic [4:0] general_outputs_oe
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  property p_wr_resp; s_wr |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_wr_busy; s_wr |=> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write not refused");
  property p_rd_resp; s_rd |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_rd_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read not refused");
  // Reset itself must quiet the outputs, so no disable here
  property p_rst; disable iff (1'b0) !aresetn |=>
    general_outputs_oe == 5'h00 && !irq && !s_axi_bvalid; endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
  property p_tsd; over_temp |=> general_outputs_oe == 5'h00 && !irq;
  endproperty
  a_tsd: assert property (p_tsd) else $error("pins live after trip");
  property p_st_hi; $rose(aresetn) && sda_in |=> selftest_req; endproperty
  a_st_hi: assert property (p_st_hi) else $error("self-test missing");
  property p_st_lo; $rose(aresetn) && !sda_in |=> !selftest_req [*4];
  endproperty
  a_st_lo: assert property (p_st_lo) else $error("self-test not held");
endmodule
bind ahg_gpio_top ahg_assertions u_chk (.*);
`default_nettype wire

// ==== tb/ahg_far_model.sv ====
// Far-side load: resolves pin levels and counts high cycles
`timescale 1ns/1ps
`default_nettype none
module ahg_far_model (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [2:0] sel,
  // Pins
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  output var int unsigned hi_cnt
);
  logic [4:0] lvl = 5'h00;
  // No pull: an undriven pin wanders, so it shows the inverse
  always @(posedge clk) begin
    lvl <= (pin_out & pin_oe) | (~lvl & ~pin_oe);
    hi_cnt <= clr ? 0 : hi_cnt + (pin_oe[sel] ? pin_out[sel] : !lvl[sel]);
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the alert heartbeat GPIO block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ahg_pkg::*;
  localparam int unsigned SLP = 20000;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [4:0]  general_outputs_out, general_outputs_oe;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp, oc_raw;
  logic        aclk, aresetn, over_temp, sda_in, selftest_req, irq, clr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  ahg_meas_t   meas;
  int unsigned hi_cnt, cyc, fail_count, n_checks;

  ahg_gpio_top #(.SLOW_CYCLES(50), .SLEEP_CYCLES(SLP)) dut (.*);
  ahg_far_model far (.clk(aclk), .clr(clr), .sel(sel), .hi_cnt(hi_cnt),
    .pin_out(general_outputs_out), .pin_oe(general_outputs_oe));

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask
  // Counts high cycles of one pin over n edges
  task automatic hi(input logic [2:0] p, input int n, input logic [31:0] e);
    @(posedge aclk);
    sel <= p;
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (n) @(posedge aclk);
    #1 chk(hi_cnt, e);
  endtask
  task automatic rst(input logic s);
    sda_in <= s;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    aclk = 1'b0;
    {aresetn, over_temp, sda_in, clr, sel, oc_raw, meas, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    rst(1'b1);
    rd(OFF_THRESH, 32'h00FF_FFFF);
    rd(8'hFC, 32'h0, RESP_SLVERR);
    wr(8'hFC, 32'h1, RESP_SLVERR);
    $display("test map done");
    wr(OFF_GPO_MODE, 32'h239);
    repeat (4) @(posedge aclk);
    chk({general_outputs_oe, general_outputs_out[4], general_outputs_out[1:0]},
        {5'h17, 3'h6});
    hi(3'd2, 1000, 500);
    $display("test modes done");
    wr(OFF_THRESH, 32'h10);
    wr(OFF_ALERT_EN, 32'h1);
    wr(OFF_HB_CFG, 32'h7);
    hi(3'd3, 1000, 500);
    meas[0] <= 24'h20;
    repeat (60) @(posedge aclk);
    meas[0] <= 24'h0;
    chk(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    hi(3'd3, 500, 0);
    rd(OFF_MAX, 32'h20);
    rd(OFF_ALERT, 32'h1);
    hi(3'd3, 1000, 500);
    chk(irq, 1'b0);
    $display("test heartbeat done");
    wr(OFF_OC_DGL, 32'h4);
    wr(OFF_HB_CFG, 32'h327);
    for (int c = 0; c < 2; c++) begin
      oc_raw <= 2'(1 << c);
      repeat (4) @(posedge aclk);
      oc_raw <= 2'h0;
      rd(OFF_ALERT, 32'h0);
      oc_raw <= 2'(1 << c);
      repeat (10) @(posedge aclk);
      hi(3'd4, 600, 0);
      oc_raw <= 2'h0;
      rd(OFF_ALERT, 32'h80 << c);
    end
    $display("test overcurrent done");
    wr(OFF_CTRL, 32'h1);
    rd(OFF_STATUS, 32'h1);
    chk(general_outputs_oe, 5'h00);
    wr(OFF_CTRL, 32'h2);
    $display("test sleep done");
    rst(1'b1);
    wr(OFF_GPO_MODE, 32'h2AA);
    repeat (SLP - 100) @(posedge aclk);
    rd(OFF_STATUS, 32'h0);
    repeat (200) @(posedge aclk);
    rd(OFF_STATUS, 32'h1);
    chk(general_outputs_oe, 5'h00);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_THRESH, 32'h5);
    over_temp <= 1'b1;
    @(posedge aclk);
    over_temp <= 1'b0;
    rd(OFF_THRESH, 32'h00FF_FFFF);
    rd(OFF_STATUS, 32'h4);
    rd(OFF_STATUS, 32'h0);
    $display("test auto sleep done");
    rst(1'b0);
    repeat (SLP + 100) @(posedge aclk);
    rd(OFF_STATUS, 32'h2);
    $display("test strap done");
    results();
  end
endmodule
`default_nettype wire
